// File: design/ssc_id_stream_regs.sv
`timescale 1ns/1ps
module ssc_id_stream_regs
  import ssc_pkg::*;
#(
  parameter logic [3:0] FAMILY_CLASS = DEF_FAMILY_CLASS,
  parameter logic [15:0] PART_CODE = DEF_PART_CODE,
  parameter logic [3:0] GRADE = DEF_GRADE,
  parameter logic [3:0] REVISION = DEF_REVISION,
  parameter logic [7:0] IF_REVISION = DEF_IF_REVISION,
  parameter logic [15:0] MAKER_CODE = DEF_MAKER_CODE
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic txn_start_i,
  input wire logic [14:0] start_addr_i,
  input wire logic byte_valid_i,
  input wire logic byte_write_i,
  input wire logic [7:0] byte_wdata_i,
  input wire logic txn_end_i,
  input wire logic single_instruction_i,
  input wire logic addr_ascending_i,
  output logic [14:0] access_addr_o,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic rdata_hit_o,
  output logic [1:0] lane_mode_o,
  output logic [7:0] loop_count_o,
  output logic in_txn_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACTIVE = 2'b10
  } ssc_state_t;

  // Transaction sequencing state
  ssc_state_t state_q;
  ssc_state_t state_d;
  ssc_pos_t pos_q;
  ssc_pos_t pos_d;
  logic [14:0] start_q;
  logic [14:0] start_d;

  // Register state
  logic [7:0] scratch_q;
  logic [7:0] scratch_d;
  logic [7:0] loop_q;
  logic [7:0] loop_d;
  ssc_xfer_cfg_t xfer_q;
  ssc_xfer_cfg_t xfer_d;

  // Read path state
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic rhit_q;
  logic rhit_d;

  logic data_byte;
  logic wr_byte;
  logic rd_byte;
  ssc_step_ctl_t step_ctl;
  ssc_pos_t step_next;
  logic [7:0] rmux;
  logic rmux_hit;

  // Bytes outside a transaction are not data and are dropped
  assign data_byte = (state_q == ST_ACTIVE) && byte_valid_i;
  assign wr_byte = data_byte && byte_write_i;
  assign rd_byte = data_byte && !byte_write_i;

  // Loop length read live, so a stream may reprogram it mid-flight
  assign step_ctl.single_instr = single_instruction_i; // R11
  assign step_ctl.ascending = addr_ascending_i; // R18
  assign step_ctl.loop_len = loop_q; // R10

  ssc_addr_step u_step (
    .cur_i(pos_q),
    .start_addr_i(start_q),
    .ctl_i(step_ctl),
    .next_o(step_next)
  );

  // Sequencing
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    start_d = start_q;
    unique case (state_q)
      ST_IDLE: begin
        if (txn_start_i) begin
          state_d = ST_ACTIVE;
          pos_d.addr = start_addr_i;
          pos_d.count = 8'h00;
          start_d = start_addr_i;
        end
      end
      ST_ACTIVE: begin
        if (byte_valid_i) begin
          pos_d = step_next; // R17
        end
        if (txn_end_i) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // Start wins over a byte and an end, soft reset wins over start: a new frame restarts the address
    if (txn_start_i) begin
      state_d = ST_ACTIVE;
      pos_d.addr = start_addr_i;
      pos_d.count = 8'h00;
      start_d = start_addr_i;
    end
    if (soft_reset_i) begin
      state_d = ST_IDLE;
      pos_d = '0;
      start_d = '0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      pos_q <= '0;
      start_q <= 15'h0000;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      start_q <= start_d;
    end
  end

  // Writable registers
  always_comb begin
    scratch_d = scratch_q;
    loop_d = loop_q;
    xfer_d = xfer_q;
    if (wr_byte) begin
      unique case (pos_q.addr)
        OFS_SCRATCH: scratch_d = byte_wdata_i; // R6
        OFS_LOOP_COUNT: loop_d = byte_wdata_i; // R10
        // Reserved bits never take a written one
        OFS_XFER_CFG: xfer_d = byte_wdata_i & XFER_WR_MASK; // R19 R14
        default: ; // R19
      endcase
    end
    // A byte written in the closing cycle counts before the clear
    if (txn_end_i && (state_q == ST_ACTIVE) && !xfer_d.keep_loop) begin // R16
      loop_d = RST_LOOP_COUNT; // R15
    end
    if (soft_reset_i) begin
      scratch_d = RST_SCRATCH;
      loop_d = RST_LOOP_COUNT;
      xfer_d = RST_XFER_CFG;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scratch_q <= RST_SCRATCH;
      loop_q <= RST_LOOP_COUNT;
      xfer_q <= RST_XFER_CFG;
    end else begin
      scratch_q <= scratch_d;
      loop_q <= loop_d;
      xfer_q <= xfer_d;
    end
  end

  // Read decode
  always_comb begin
    rmux = 8'h00;
    rmux_hit = 1'b1;
    unique case (pos_q.addr)
      OFS_FAMILY_CLASS: rmux = {4'h0, FAMILY_CLASS}; // R1
      OFS_PART_LOW: rmux = PART_CODE[7:0]; // R3
      OFS_PART_HIGH: rmux = PART_CODE[15:8]; // R4
      OFS_GRADE_REV: rmux = {GRADE, REVISION}; // R5
      OFS_SCRATCH: rmux = scratch_q; // R6
      OFS_IF_REVISION: rmux = IF_REVISION; // R7
      OFS_MAKER_LOW: rmux = MAKER_CODE[7:0]; // R8
      OFS_MAKER_HIGH: rmux = MAKER_CODE[15:8]; // R9
      OFS_LOOP_COUNT: rmux = loop_q;
      OFS_XFER_CFG: rmux = xfer_q & XFER_WR_MASK; // R19
      default: begin
        // Other offsets belong to neighbouring logic
        rmux = 8'h00;
        rmux_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    rhit_d = rhit_q;
    if (rd_byte) begin
      rdata_d = rmux;
      rvalid_d = 1'b1;
      rhit_d = rmux_hit;
    end
    if (soft_reset_i) begin
      rdata_d = 8'h00;
      rvalid_d = 1'b0;
      rhit_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rhit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rhit_q <= rhit_d;
    end
  end

  assign access_addr_o = pos_q.addr;
  assign rdata_o = rdata_q;
  assign rdata_valid_o = rvalid_q;
  assign rdata_hit_o = rhit_q;
  // Lane count is held in a flop; the serial shell follows it
  assign lane_mode_o = xfer_q.lane_mode; // R14
  assign loop_count_o = loop_q;
  assign in_txn_o = (state_q == ST_ACTIVE);

endmodule

// File: shared/ssc_pkg.sv
// What this block does
// R1: Chip class byte: low nibble holds family class code, upper nibble reads zero.
// R2: Host identifies the part from class code together with part code.
// R3: Low byte of the sixteen-bit part code is a read-only byte.
// R4: High byte of the part code is read-only at the next address.
// R5: Grade byte: test grade in bits 7..4, silicon revision in 3..0.
// R6: Scratch byte resets to zero, stores writes, reads back, nothing else.
// R7: Serial interface protocol revision is a fixed read-only byte.
// R8: Low byte of the sixteen-bit maker code is read-only.
// R9: High byte of the maker code is read-only at the next address.
// R10: Nonzero loop count returns address to start after that many data bytes.
// R11: Loop count matters only in streaming, ignored in single-instruction access.
// R12: Loop count zero disables looping; address wraps at register space limits.
// R13: Host expects at most 255 bytes per looped segment.
// R14: Lane mode bits 7..6: 00 single lane, 01 dual lane.
// R15: Retain bit clear clears loop count at each transaction end.
// R16: Retain bit set keeps loop count across transactions.
// R17: Access mode zero streams with address stepping; one is single-instruction.
// R18: Direction zero decrements address per byte; one increments.
// R19: Writes to read-only registers and reserved bits ignored; reserved reads zero.
package ssc_pkg;

  localparam int ADDR_W = 15;

  // Register offsets
  localparam logic [14:0] OFS_FAMILY_CLASS = 15'h0003;
  localparam logic [14:0] OFS_PART_LOW = 15'h0004;
  localparam logic [14:0] OFS_PART_HIGH = 15'h0005;
  localparam logic [14:0] OFS_GRADE_REV = 15'h0006;
  localparam logic [14:0] OFS_SCRATCH = 15'h000a;
  localparam logic [14:0] OFS_IF_REVISION = 15'h000b;
  localparam logic [14:0] OFS_MAKER_LOW = 15'h000c;
  localparam logic [14:0] OFS_MAKER_HIGH = 15'h000d;
  localparam logic [14:0] OFS_LOOP_COUNT = 15'h000e;
  localparam logic [14:0] OFS_XFER_CFG = 15'h000f;

  // Field positions
  localparam int POS_LANE_MODE = 6;
  localparam int POS_KEEP_LOOP = 2;

  // Lane mode codes
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;

  // Writable bits of the transfer configuration byte
  localparam logic [7:0] XFER_WR_MASK = 8'hc4;

  // Values after reset
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_LOOP_COUNT = 8'h00;
  localparam logic [7:0] RST_XFER_CFG = 8'h00;

  // Identity defaults; values are arbitrary
  localparam logic [3:0] DEF_FAMILY_CLASS = 4'h7;
  localparam logic [15:0] DEF_PART_CODE = 16'h1234;
  localparam logic [3:0] DEF_GRADE = 4'h1;
  localparam logic [3:0] DEF_REVISION = 4'h2;
  localparam logic [7:0] DEF_IF_REVISION = 8'h21;
  localparam logic [15:0] DEF_MAKER_CODE = 16'ha5c3;

  typedef struct packed {
    logic [1:0] lane_mode;
    logic [2:0] rsvd_hi;
    logic keep_loop;
    logic [1:0] rsvd_lo;
  } ssc_xfer_cfg_t;

  typedef struct packed {
    logic single_instr;
    logic ascending;
    logic [7:0] loop_len;
  } ssc_step_ctl_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] count;
  } ssc_pos_t;

endpackage

// File: design/ssc_addr_step.sv
`timescale 1ns/1ps
module ssc_addr_step
  import ssc_pkg::*;
(
  input wire ssc_pos_t cur_i,
  input wire logic [14:0] start_addr_i,
  input wire ssc_step_ctl_t ctl_i,
  output ssc_pos_t next_o
);

  logic [7:0] count_inc;
  logic [14:0] addr_inc;
  logic [14:0] addr_dec;

  assign count_inc = cur_i.count + 8'h01;
  // Modulo arithmetic gives the wrap at both ends of the space
  assign addr_inc = cur_i.addr + 15'h0001; // R12
  assign addr_dec = cur_i.addr - 15'h0001; // R12

  always_comb begin
    next_o = cur_i;
    if (ctl_i.single_instr) begin
      // No stepping and no looping in single-instruction access
      next_o = cur_i; // R11 R17
    end else if (ctl_i.loop_len != 8'h00 && count_inc == ctl_i.loop_len) begin
      next_o.addr = start_addr_i; // R10
      next_o.count = 8'h00; // R10
    end else begin
      next_o.addr = ctl_i.ascending ? addr_inc : addr_dec; // R18 R17
      next_o.count = count_inc;
    end
  end

endmodule

// File: dv/ssc_regs_checker.sv
`timescale 1ns/1ps
module ssc_regs_checker
  import ssc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic txn_start_i,
  input wire logic [14:0] start_addr_i,
  input wire logic byte_valid_i,
  input wire logic byte_write_i,
  input wire logic [7:0] byte_wdata_i,
  input wire logic txn_end_i,
  input wire logic single_instruction_i,
  input wire logic addr_ascending_i,
  input wire logic [14:0] access_addr_o,
  input wire logic [7:0] rdata_o,
  input wire logic rdata_valid_o,
  input wire logic rdata_hit_o,
  input wire logic [1:0] lane_mode_o,
  input wire logic [7:0] loop_count_o,
  input wire logic in_txn_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Start and soft reset override the address step of any byte in their cycle
  wire go = in_txn_o && !txn_start_i && !soft_reset_i;
  wire b = go && byte_valid_i;
  // A config write lands even in a start cycle; only soft reset blocks it
  wire wcfg = in_txn_o && byte_valid_i && byte_write_i && !soft_reset_i &&
    access_addr_o == OFS_XFER_CFG;
  logic keep_q, keep_d;
  always_comb begin
    keep_d = wcfg ? byte_wdata_i[POS_KEEP_LOOP] : keep_q;
    if (soft_reset_i)
      keep_d = 1'b0;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      keep_q <= 1'b0;
    else
      keep_q <= keep_d;
  end
  rd_pulse_a: assert property (b && !byte_write_i |=> rdata_valid_o)
    else $error("read not answered");
  miss_zero_a: assert property (rdata_valid_o && !rdata_hit_o |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  start_addr_a: assert property (txn_start_i && !soft_reset_i |=> in_txn_o &&
    access_addr_o == $past(start_addr_i)) else $error("start address not taken");
  hold_addr_a: assert property (go && (!byte_valid_i || single_instruction_i)
    |=> $stable(access_addr_o)) else $error("address moved");
  step_a: assert property (b && !single_instruction_i && loop_count_o == 8'h00 &&
    access_addr_o != OFS_LOOP_COUNT |=> access_addr_o == $past(access_addr_o) +
    ($past(addr_ascending_i) ? 15'h0001 : 15'h7fff)) else $error("bad address step");
  lane_src_a: assert property ($changed(lane_mode_o) |-> $past(soft_reset_i || wcfg))
    else $error("lane mode changed without write");
  loop_clr_a: assert property (txn_end_i && go && !keep_d |=> loop_count_o == 8'h00)
    else $error("loop count not cleared");
  loop_keep_a: assert property (txn_end_i && go && keep_d && !byte_valid_i
    |=> $stable(loop_count_o)) else $error("loop count lost");
  valid_src_a: assert property (rdata_valid_o |-> $past(in_txn_o && byte_valid_i &&
    !byte_write_i && !soft_reset_i)) else $error("read data without read");
  rdata_hold_a: assert property (!rdata_valid_o && !$past(soft_reset_i)
    |-> $stable(rdata_o)) else $error("read data not held");
  end_close_a: assert property (txn_end_i && go |=> !in_txn_o)
    else $error("transaction not closed");
  cover property (b && loop_count_o != 8'h00);
  cover property (txn_end_i && go && keep_d);
  cover property (b && single_instruction_i);
endmodule

bind ssc_id_stream_regs ssc_regs_checker ssc_regs_checker_i (.*);

// File: dv/ssc_host_model.sv
`timescale 1ns/1ps
module ssc_host_model (
  input wire logic clk_i,
  output logic txn_start_o,
  output logic [14:0] start_addr_o,
  output logic byte_valid_o,
  output logic byte_write_o,
  output logic [7:0] byte_wdata_o,
  output logic txn_end_o
);
  initial begin
    txn_start_o = 1'b0;
    start_addr_o = 15'h0000;
    byte_valid_o = 1'b0;
    byte_write_o = 1'b0;
    byte_wdata_o = 8'h00;
    txn_end_o = 1'b0;
  end
  // Tasks enter and leave at a falling edge
  task automatic open_txn(input logic [14:0] a);
    txn_start_o = 1'b1;
    start_addr_o = a;
    @(negedge clk_i);
    txn_start_o = 1'b0;
    start_addr_o = ~a;
  endtask
  // Valid stays up between bytes so back-to-back bytes need no gap
  task automatic put(input logic w, input logic [7:0] d);
    byte_valid_o = 1'b1;
    byte_write_o = w;
    byte_wdata_o = d;
    @(negedge clk_i);
  endtask
  // Close drops valid and raises end for one cycle
  task automatic close_txn;
    byte_valid_o = 1'b0;
    txn_end_o = 1'b1;
    @(negedge clk_i);
    txn_end_o = 1'b0;
  endtask
endmodule

// File: dv/ssc_id_stream_regs_tb.sv
`timescale 1ns/1ps
module ssc_id_stream_regs_tb;
  import ssc_pkg::*;
  logic clk_i, reset_n_i, soft_reset_i, single_instruction_i, addr_ascending_i;
  logic txn_start_i, byte_valid_i, byte_write_i, txn_end_i, rdata_valid_o, rdata_hit_o, in_txn_o;
  logic [14:0] start_addr_i, access_addr_o;
  logic [7:0] byte_wdata_i, rdata_o, loop_count_o, sc, lc, cfg;
  logic [1:0] lane_mode_o;
  int n_fail = 0;
  int num_checks = 0;
  ssc_id_stream_regs ssc_id_stream_regs_i (.*);
  ssc_host_model ssc_host_model_i (.clk_i, .txn_start_o(txn_start_i), .start_addr_o(start_addr_i),
    .byte_valid_o(byte_valid_i), .byte_write_o(byte_write_i), .byte_wdata_o(byte_wdata_i),
    .txn_end_o(txn_end_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [8:0] exp_rd(input logic [14:0] a);
    case (a)
      OFS_FAMILY_CLASS: return {5'h10, DEF_FAMILY_CLASS};
      OFS_PART_LOW: return {1'b1, DEF_PART_CODE[7:0]};
      OFS_PART_HIGH: return {1'b1, DEF_PART_CODE[15:8]};
      OFS_GRADE_REV: return {1'b1, DEF_GRADE, DEF_REVISION};
      OFS_SCRATCH: return {1'b1, sc};
      OFS_IF_REVISION: return {1'b1, DEF_IF_REVISION};
      OFS_MAKER_LOW: return {1'b1, DEF_MAKER_CODE[7:0]};
      OFS_MAKER_HIGH: return {1'b1, DEF_MAKER_CODE[15:8]};
      OFS_LOOP_COUNT: return {1'b1, lc};
      OFS_XFER_CFG: return {1'b1, cfg};
      default: return 9'h000;
    endcase
  endfunction
  // One transaction of n bytes from a0; expected addresses from the mirror
  task automatic seq(input logic [14:0] a0, input int n, input logic w, input logic [7:0] d);
    logic [14:0] a;
    logic [7:0] v;
    a = a0;
    ssc_host_model_i.open_txn(a0);
    chk("in_txn", {15'h0, in_txn_o}, 16'h0001);
    for (int k = 1; k <= n; k++) begin
      v = n > 1 ? 8'($urandom) : d;
      chk("access_addr", {1'b0, access_addr_o}, {1'b0, a});
      ssc_host_model_i.put(w, v);
      if (!w)
        chk("rdata", {6'h0, rdata_valid_o, rdata_hit_o, rdata_o}, {7'h1, exp_rd(a)});
      else if (a == OFS_SCRATCH)
        sc = v;
      else if (a == OFS_LOOP_COUNT)
        lc = v;
      else if (a == OFS_XFER_CFG)
        cfg = v & XFER_WR_MASK;
      if (!single_instruction_i)
        a = (lc != 8'h00 && k % lc == 0) ? a0 : (addr_ascending_i ? a + 15'h1 : a - 15'h1);
    end
    ssc_host_model_i.close_txn();
    chk("in_txn", {15'h0, in_txn_o}, 16'h0000);
    if (!cfg[POS_KEEP_LOOP])
      lc = 8'h00;
    chk("loop_count", {8'h0, loop_count_o}, {8'h0, lc});
    chk("lane_mode", {14'h0, lane_mode_o}, {14'h0, cfg[7:6]});
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2d9e));
    reset_n_i = 1'b0;
    soft_reset_i = 1'b0;
    single_instruction_i = 1'b0;
    addr_ascending_i = 1'b1;
    sc = 8'h00;
    lc = 8'h00;
    cfg = 8'h00;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    seq(15'h0000, 16, 1'b0, 8'h00);
    seq(15'h0000, 14, 1'b1, 8'h00);
    seq(15'h0000, 16, 1'b0, 8'h00);
    seq(OFS_XFER_CFG, 1, 1'b1, 8'h7f);
    seq(OFS_LOOP_COUNT, 1, 1'b1, 8'h03);
    seq(OFS_SCRATCH, 7, 1'b0, 8'h00);
    single_instruction_i = 1'b1;
    seq(OFS_SCRATCH, 4, 1'b0, 8'h00);
    single_instruction_i = 1'b0;
    addr_ascending_i = 1'b0;
    seq(OFS_XFER_CFG, 1, 1'b1, 8'hbb);
    seq(15'h0002, 4, 1'b0, 8'h00);
    addr_ascending_i = 1'b1;
    seq(15'h7ffe, 3, 1'b0, 8'h00);
    soft_reset_i = 1'b1;
    @(negedge clk_i);
    soft_reset_i = 1'b0;
    sc = 8'h00;
    cfg = 8'h00;
    @(negedge clk_i);
    seq(15'h0008, 8, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule
